//--- testbench.sv
/*
  Self-checking bench of the general register group.
  Assumes the design header and package are compiled first.
*/
`include "vgagr_params.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   ref_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic [15:0]            io_addr;
  logic                   io_wr, io_rd, io_rack_ff, mem_req, pixel_diag_map, ext_clock_used, mem_grant_ff;
  logic [7:0]             io_wdata, io_rdata_ff, sequencer_ext_seg_ctrl, d, f, m, en, rv;
  logic [1:0]             color_plane_sel;
  logic [3:0]             ext_freq_select;
  logic                   ack, monitor_vsync_ff;
  vgagr_pkg::vgagr_pins_s pins_in;
  vgagr_pkg::vgagr_ctrl_s ctrl_ff;
  int                     fails = 0;
  int                     compares = 0;
  // Ports that must read back zero after reset
  logic [15:0]            rst_ports [4] = '{`VGAGR_PORT_MISC_R, `VGAGR_PORT_FEAT_R,
                                            `VGAGR_PORT_VGAEN, `VGAGR_PORT_SEG_WR};

  always #4 ref_clk = ~ref_clk;

  vgagr_general_regs vgagr_general_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .io_rack_ff(io_rack_ff),
    .pins_in(pins_in), .color_plane_sel(color_plane_sel), .pixel_diag_map(pixel_diag_map),
    .sequencer_ext_seg_ctrl(sequencer_ext_seg_ctrl), .ext_clock_used(ext_clock_used),
    .ext_freq_select(ext_freq_select), .mem_req(mem_req), .ctrl_ff(ctrl_ff),
    .mem_grant_ff(mem_grant_ff), .monitor_vsync_ff(monitor_vsync_ff));

  vgagr_host_model vgagr_host_model_i (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .io_rack_ff(io_rack_ff));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read with data mask; the acknowledge must match too
  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp, input logic ea,
                       input logic [7:0] mk);
    vgagr_host_model_i.rd(a, rv, ack);
    chk(what, {7'h00, ea, exp & mk}, {7'h00, ack, rv & mk});
  endtask

  // Code 10, and 11 without external clock, settle to the first code
  function automatic logic [3:0] exp_clk(logic [1:0] c, logic eu, logic [3:0] ef);
    return (c == 2'b01) ? `VGAGR_CLK_28M : (c == 2'b11 && eu) ? ef : `VGAGR_CLK_25M;
  endfunction

  function automatic logic [7:0] exp_is1(vgagr_pkg::vgagr_pins_s p, logic [1:0] c, logic pm);
    logic [1:0] dg;
    logic [7:0] x;
    x = p.pixel;
    if (pm) dg = (c == 0) ? {x[2], x[0]} : (c == 1) ? {x[5], x[4]} : (c == 2) ? {x[3], x[1]} : {x[7], x[6]};
    else dg = (c == 0) ? {p.red, p.blue} : (c == 1) ? {p.sec_red, p.sec_green} : {p.sec_blue, p.green};
    return {2'b00, dg, p.vretrace, 2'b00, ~p.disp_en};
  endfunction

  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: the run needs well under 5000 cycles
  initial begin
    #200000;
    fails++;
    $display("watchdog expired");
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pins_in = '0;
    {color_plane_sel, pixel_diag_map, sequencer_ext_seg_ctrl, ext_clock_used, ext_freq_select, mem_req} = '0;
    void'($urandom(32'he4aa));
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    // Reset values, read-only port writes ignored, unmapped read refused
    vgagr_host_model_i.wr(`VGAGR_PORT_MISC_R, 8'hff);
    vgagr_host_model_i.wr(`VGAGR_PORT_FEAT_R, 8'hff);
    // Misc 00 is the invalid polarity pair, so only that flag stands after reset
    chk("ctrl reset", 16'h0001, {14'h0, (ctrl_ff[26:23] != 4'h0) || (ctrl_ff[21:0] != 22'h0),
        ctrl_ff.sync_invalid});
    foreach (rst_ports[k]) begin
      rdchk("reset read", rst_ports[k], 8'h00, 1'b1, 8'hff);
    end
    rdchk("unmapped", 16'h03c0, 8'h00, 1'b0, 8'hff);
    $display("test reset done");
    // Miscellaneous output fields, every clock code
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      d[3:2] = i[1:0];
      ext_clock_used = i[2];
      ext_freq_select = 4'($urandom);
      mem_req = i[3];
      vgagr_host_model_i.wr(`VGAGR_PORT_MISC_W, d);
      chk("misc fields", {8'h00, d[7:6], d[7:6], d[7:6] == 2'b00, d[5], d[1], d[0]},
          {8'h00, ctrl_ff.vsync_neg, ctrl_ff.hsync_neg, ctrl_ff.lines, ctrl_ff.sync_invalid,
           ctrl_ff.page_high, ctrl_ff.mem_access_en, ctrl_ff.color_emul});
      chk("clock select", {12'h000, exp_clk(d[3:2], i[2], ext_freq_select)},
          {12'h000, ctrl_ff.video_clock_freq_select});
      @(posedge ref_clk);
      #1;
      chk("mem grant", {15'h0, d[1] & i[3]}, {15'h0, mem_grant_ff});
      rdchk("misc read", `VGAGR_PORT_MISC_R, d & `VGAGR_MISC_MASK, 1'b1, 8'hff);
    end
    $display("test misc done");
    // Feature write decode by address set, monitor sync select
    f = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m = 8'($urandom);
      m[0] = i[0];
      vgagr_host_model_i.wr(`VGAGR_PORT_MISC_W, m);
      // A misc write leaves the feature value alone
      rdchk("feat hold", `VGAGR_PORT_FEAT_R, f, 1'b1, 8'hff);
      d = 8'($urandom);
      vgagr_host_model_i.wr(i[1] ? `VGAGR_PORT_IS1_COLOR : `VGAGR_PORT_IS1_MONO, d);
      // A write at the port of the other set is ignored
      if (i[1] == i[0]) begin
        f = d & `VGAGR_FEAT_MASK;
      end
      rdchk("feat read", `VGAGR_PORT_FEAT_R, f, 1'b1, 8'hff);
      rdchk("wrong set", i[0] ? `VGAGR_PORT_IS1_MONO : `VGAGR_PORT_IS1_COLOR, 8'h00, 1'b0, 8'hff);
      pins_in.vsync = i[2];
      pins_in.vde = 1'($urandom);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("mon vsync", {15'h0, (i[2] | (f[3] & pins_in.vde)) ^ m[7]}, {15'h0, monitor_vsync_ff});
    end
    $display("test feature done");
    // Status reads, both diagnostic mappings with every plane code
    for (int i = 0; i < 16; i++) begin
      pins_in = 20'($urandom);
      color_plane_sel = i[1:0];
      pixel_diag_map = i[2];
      repeat (4) @(posedge ref_clk);
      rdchk("status0", `VGAGR_PORT_MISC_W, {pins_in.irq_pending, 2'b00, pins_in.switch_sense, 4'h0}, 1'b1,
            8'hff);
      rdchk("status1", m[0] ? `VGAGR_PORT_IS1_COLOR : `VGAGR_PORT_IS1_MONO, exp_is1(pins_in, i[1:0], i[2]),
            1'b1, (!i[2] && i[1:0] == 2'b11) ? 8'hcf : 8'hff);
    end
    $display("test status done");
    // Enable register: each port writes its own bit only
    en = 8'h00;
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      vgagr_host_model_i.wr(i[0] ? `VGAGR_PORT_VGAEN_ALT : `VGAGR_PORT_VGAEN, d);
      if (i[0]) en[3] = d[3];
      else en[0] = d[0];
      chk("vga enable", {15'h0, en[0] | en[3]}, {15'h0, ctrl_ff.vga_enable});
      rdchk("enable read", i[1] ? `VGAGR_PORT_VGAEN_ALT : `VGAGR_PORT_VGAEN, en, 1'b1, 8'hff);
    end
    $display("test enable done");
    // Segment registers in single and dual mode
    for (int i = 0; i < 8; i++) begin
      sequencer_ext_seg_ctrl = 8'($urandom);
      sequencer_ext_seg_ctrl[`VGAGR_SRB_DUAL] = i[0];
      d = 8'($urandom);
      f = 8'($urandom);
      vgagr_host_model_i.wr(`VGAGR_PORT_SEG_WR, d);
      vgagr_host_model_i.wr(`VGAGR_PORT_SEG_RD, f);
      rdchk("seg0", `VGAGR_PORT_SEG_WR, d & `VGAGR_SEG_MASK, 1'b1, 8'hff);
      rdchk("seg1", `VGAGR_PORT_SEG_RD, i[0] ? f & `VGAGR_SEG_MASK : 8'h00, 1'b1, 8'hff);
      chk("segments", i[0] ? {4'h0, d[5:0], f[5:0]} : {7'h00, d[5:3], 3'h0, d[2:0]},
          {4'h0, ctrl_ff.write_segment, ctrl_ff.read_segment});
    end
    $display("test segment done");
    // Second reset in mid-run clears the stored image
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    rdchk("misc rerst", `VGAGR_PORT_MISC_R, 8'h00, 1'b1, 8'hff);
    $display("test rereset done");
    close_out();
  end
endmodule

`default_nettype wire

//--- vgagr_general_regs.sv
/*
  General control and status registers of the VGA controller, reached by
  host I/O port reads and writes.
  Assumes io_rd/io_wr are one-cycle strobes on ref_clk with a stable
  address; status pins are asynchronous and are synchronised here.
*/
`include "vgagr_params.svh"
`default_nettype none

module vgagr_general_regs (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // Host I/O port bus
  input  wire logic [15:0]          io_addr,
  input  wire logic                 io_wr,
  input  wire logic                 io_rd,
  input  wire logic [7:0]           io_wdata,
  output var  logic [7:0]           io_rdata_ff,
  output var  logic                 io_rack_ff,
  // Asynchronous status pins
  input  wire vgagr_pkg::vgagr_pins_s pins_in,
  // Same-clock controls from neighbouring register groups
  input  wire logic [1:0]           color_plane_sel,
  input  wire logic                 pixel_diag_map,
  input  wire logic [7:0]           sequencer_ext_seg_ctrl,
  input  wire logic                 ext_clock_used,
  input  wire logic [3:0]           ext_freq_select,
  input  wire logic                 mem_req,
  // Control outputs
  output var  vgagr_pkg::vgagr_ctrl_s ctrl_ff,
  output var  logic                 mem_grant_ff,
  output var  logic                 monitor_vsync_ff
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  vgagr_pkg::vgagr_pins_s pins_s;

  vgagr_sync #(
    .W ($bits(vgagr_pkg::vgagr_pins_s))
  ) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       (pins_in),
    .q       (pins_s)
  );

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  vgagr_pkg::vgagr_regs_s regs_ff;
  vgagr_pkg::vgagr_regs_s nxt_regs;
  logic                   hit_is1;
  logic                   hit_shared;
  logic                   hit_misc_r;
  logic                   hit_feat_r;
  logic                   hit_vgaen;
  logic                   hit_vgaen_alt;
  logic                   hit_seg_rd;
  logic                   hit_seg_wr;

  // mono or colour status port
  // Only the port of the selected set answers; the other stays silent.
  assign hit_is1       = regs_ff.misc[`VGAGR_MISC_IOSEL] ? (io_addr == `VGAGR_PORT_IS1_COLOR)
                                                         : (io_addr == `VGAGR_PORT_IS1_MONO);
  assign hit_shared    = (io_addr == `VGAGR_PORT_MISC_W);
  assign hit_misc_r    = (io_addr == `VGAGR_PORT_MISC_R);
  assign hit_feat_r    = (io_addr == `VGAGR_PORT_FEAT_R);
  assign hit_vgaen     = (io_addr == `VGAGR_PORT_VGAEN);
  assign hit_vgaen_alt = (io_addr == `VGAGR_PORT_VGAEN_ALT);
  assign hit_seg_rd    = (io_addr == `VGAGR_PORT_SEG_RD);
  assign hit_seg_wr    = (io_addr == `VGAGR_PORT_SEG_WR);

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_regs = regs_ff;
    if (io_wr) begin
      // shared port write lands in misc
      if (hit_shared) begin
        nxt_regs.misc = io_wdata & `VGAGR_MISC_MASK;
      end
      // feature control written at status port
      if (hit_is1) begin
        nxt_regs.feat = io_wdata & `VGAGR_FEAT_MASK;
      end
      // each enable port owns one bit
      if (hit_vgaen) begin
        nxt_regs.vgaen[`VGAGR_VGAEN_MAIN] = io_wdata[`VGAGR_VGAEN_MAIN];
      end
      if (hit_vgaen_alt) begin
        nxt_regs.vgaen[`VGAGR_VGAEN_ALT] = io_wdata[`VGAGR_VGAEN_ALT];
      end
      // segment 0 keeps six bits, top two reserved
      if (hit_seg_wr) begin
        nxt_regs.seg0 = io_wdata & `VGAGR_SEG_MASK;
      end
      // segment 1 stores always, visible in dual mode only
      if (hit_seg_rd) begin
        nxt_regs.seg1 = io_wdata & `VGAGR_SEG_MASK;
      end
    end
  end

  // Register image
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regs_ff <= '{default: `VGAGR_RST_BYTE};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ----------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------
  vgagr_pkg::vgagr_ctrl_s nxt_ctrl;
  logic                   nxt_grant;
  logic                   nxt_mon_vs;
  logic                   dual_mode;
  logic [1:0]             clk_code;
  logic                   vs_src;

  assign dual_mode = sequencer_ext_seg_ctrl[`VGAGR_SRB_DUAL];
  assign clk_code  = nxt_regs.misc[`VGAGR_MISC_CLK_HI:`VGAGR_MISC_CLK_LO];

  // Decoded from next values so controls track a write in one cycle
  always_comb begin
    nxt_ctrl = '0;
    nxt_ctrl.vsync_neg    = nxt_regs.misc[`VGAGR_MISC_VPOL];
    nxt_ctrl.hsync_neg    = nxt_regs.misc[`VGAGR_MISC_HPOL];
    nxt_ctrl.lines        = vgagr_pkg::vgagr_lines_e'(nxt_regs.misc[`VGAGR_MISC_VPOL:`VGAGR_MISC_HPOL]);
    nxt_ctrl.sync_invalid = (nxt_ctrl.lines == vgagr_pkg::VGAGR_LINES_INVALID);
    nxt_ctrl.page_high    = nxt_regs.misc[`VGAGR_MISC_PAGE];
    // clock select; unspecified codes fall back to the 25 MHz code
    unique case (clk_code)
      2'b00: nxt_ctrl.video_clock_freq_select = `VGAGR_CLK_25M;
      2'b01: nxt_ctrl.video_clock_freq_select = `VGAGR_CLK_28M;
      2'b10: nxt_ctrl.video_clock_freq_select = `VGAGR_CLK_25M;
      2'b11: nxt_ctrl.video_clock_freq_select = ext_clock_used ? ext_freq_select : `VGAGR_CLK_25M;
    endcase
    nxt_ctrl.mem_access_en = nxt_regs.misc[`VGAGR_MISC_RAMEN];
    nxt_ctrl.color_emul    = nxt_regs.misc[`VGAGR_MISC_IOSEL];
    nxt_ctrl.vsync_or_vde  = nxt_regs.feat[`VGAGR_FEAT_VSSEL];
    // either port bit enables the display
    nxt_ctrl.vga_enable    = nxt_regs.vgaen[`VGAGR_VGAEN_MAIN] | nxt_regs.vgaen[`VGAGR_VGAEN_ALT];
    nxt_ctrl.dual_seg      = dual_mode;
    if (dual_mode) begin
      nxt_ctrl.write_segment = nxt_regs.seg0[`VGAGR_SEG_HI_HI:`VGAGR_SEG_LO_LO];
      nxt_ctrl.read_segment  = nxt_regs.seg1[`VGAGR_SEG_HI_HI:`VGAGR_SEG_LO_LO];
    end else begin
      nxt_ctrl.write_segment = {3'h0, nxt_regs.seg0[`VGAGR_SEG_HI_HI:`VGAGR_SEG_HI_LO]};
      nxt_ctrl.read_segment  = {3'h0, nxt_regs.seg0[`VGAGR_SEG_LO_HI:`VGAGR_SEG_LO_LO]};
    end
    nxt_grant = mem_req & nxt_regs.misc[`VGAGR_MISC_RAMEN];
    vs_src     = pins_s.vsync | (nxt_regs.feat[`VGAGR_FEAT_VSSEL] & pins_s.vde);
    nxt_mon_vs = vs_src ^ nxt_regs.misc[`VGAGR_MISC_VPOL];
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_ff          <= '0;
      mem_grant_ff     <= 1'b0;
      monitor_vsync_ff <= 1'b0;
    end else begin
      ctrl_ff          <= nxt_ctrl;
      mem_grant_ff     <= nxt_grant;
      monitor_vsync_ff <= nxt_mon_vs;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] nxt_rdata;
  logic       nxt_rack;
  logic [7:0] is0_val;
  logic [7:0] is1_val;
  logic [1:0] diag;

  always_comb begin
    diag = 2'h0;
    unique case (vgagr_pkg::vgagr_cpe_e'(color_plane_sel))
      vgagr_pkg::VGAGR_CPE_0: diag = pixel_diag_map ? {pins_s.pixel[2], pins_s.pixel[0]}
                                                    : {pins_s.red, pins_s.blue};
      vgagr_pkg::VGAGR_CPE_1: diag = pixel_diag_map ? {pins_s.pixel[5], pins_s.pixel[4]}
                                                    : {pins_s.sec_red, pins_s.sec_green};
      vgagr_pkg::VGAGR_CPE_2: diag = pixel_diag_map ? {pins_s.pixel[3], pins_s.pixel[1]}
                                                    : {pins_s.sec_blue, pins_s.green};
      vgagr_pkg::VGAGR_CPE_3: diag = pixel_diag_map ? {pins_s.pixel[7], pins_s.pixel[6]}
                                                    : 2'h0;
    endcase
    is0_val = `VGAGR_RST_BYTE;
    is0_val[`VGAGR_IS0_IRQ]     = pins_s.irq_pending;
    is0_val[`VGAGR_IS0_SWSENSE] = pins_s.switch_sense;
    is1_val = `VGAGR_RST_BYTE;
    is1_val[`VGAGR_IS1_DIAG_HI:`VGAGR_IS1_DIAG_LO] = diag;
    is1_val[`VGAGR_IS1_VRETR] = pins_s.vretrace;
    is1_val[`VGAGR_IS1_DISPN] = ~pins_s.disp_en;
    // Unmapped reads return zero with no acknowledge
    nxt_rdata = `VGAGR_RST_BYTE;
    nxt_rack  = 1'b0;
    if (io_rd) begin
      nxt_rack = 1'b1;
      // shared port read is status 0
      if (hit_shared) begin
        nxt_rdata = is0_val;
      end else if (hit_is1) begin
        nxt_rdata = is1_val;
      end else if (hit_misc_r) begin
        nxt_rdata = regs_ff.misc;
      end else if (hit_feat_r) begin
        nxt_rdata = regs_ff.feat;
      end else if (hit_vgaen | hit_vgaen_alt) begin
        nxt_rdata = regs_ff.vgaen;
      end else if (hit_seg_wr) begin
        nxt_rdata = regs_ff.seg0;
      end else if (hit_seg_rd) begin
        nxt_rdata = dual_mode ? regs_ff.seg1 : `VGAGR_RST_BYTE;
      end else begin
        nxt_rack = 1'b0;
      end
    end
  end

  // Read data register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      io_rdata_ff <= `VGAGR_RST_BYTE;
      io_rack_ff  <= 1'b0;
    end else begin
      io_rdata_ff <= nxt_rdata;
      io_rack_ff  <= nxt_rack;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  misc_store_a: assert property (io_wr && hit_shared |=>
    ctrl_ff.vsync_neg == $past(io_wdata[7]) && ctrl_ff.page_high == $past(io_wdata[5]))
    else $error("misc write not reflected in controls");
  clk_sel_a: assert property (regs_ff.misc[3:2] == 2'b01 |-> ctrl_ff.video_clock_freq_select == 4'h1)
    else $error("clock select code wrong");
  mem_gate_a: assert property (mem_grant_ff |-> $past(mem_req) && regs_ff.misc[1])
    else $error("memory access granted while disabled");
  is1_decode_a: assert property (io_rd && !regs_ff.misc[0] && io_addr == 16'h03da |=> !io_rack_ff)
    else $error("colour status port answered in mono mode");
  feat_read_a: assert property (io_rd && hit_feat_r |=> io_rack_ff && io_rdata_ff[7:4] == 4'h0
    && io_rdata_ff[2:0] == 3'h0)
    else $error("feature reserved bits not zero");
  is0_read_a: assert property (io_rd && hit_shared |=>
    io_rdata_ff[7] == $past(pins_s.irq_pending) && io_rdata_ff[4] == $past(pins_s.switch_sense))
    else $error("status 0 read wrong");
  retrace_bits_a: assert property (io_rd && hit_is1 && !hit_shared |=>
    io_rdata_ff[3] == $past(pins_s.vretrace) && io_rdata_ff[0] == !$past(pins_s.disp_en))
    else $error("retrace status bits wrong");
  diag_color_a: assert property (io_rd && hit_is1 && !pixel_diag_map && color_plane_sel == 2'b00 |=>
    io_rdata_ff[5:4] == {$past(pins_s.red), $past(pins_s.blue)})
    else $error("colour diagnostic read-back wrong");
  diag_pixel_a: assert property (io_rd && hit_is1 && pixel_diag_map && color_plane_sel == 2'b11 |=>
    io_rdata_ff[5:4] == $past(pins_s.pixel[7:6]))
    else $error("pixel diagnostic read-back wrong");
  vgaen_port_a: assert property (io_wr && hit_vgaen_alt |=>
    regs_ff.vgaen[0] == $past(regs_ff.vgaen[0]) && regs_ff.vgaen[3] == $past(io_wdata[3]))
    else $error("alternate enable port touched wrong bit");
  seg_single_a: assert property (!ctrl_ff.dual_seg |-> ctrl_ff.read_segment[5:3] == 3'h0
    && ctrl_ff.write_segment == {3'h0, regs_ff.seg0[5:3]})
    else $error("single segment split wrong");

  misc_wr_c: cover property (io_wr && hit_shared ##1 ctrl_ff.lines == vgagr_pkg::VGAGR_LINES_480);
  is1_rd_c: cover property (regs_ff.misc[0] && io_rd && hit_is1 ##1 io_rack_ff);
  alt_en_c: cover property (io_wr && hit_vgaen_alt ##1 ctrl_ff.vga_enable);
  dual_c: cover property (ctrl_ff.dual_seg && ctrl_ff.read_segment != 6'h00);

endmodule

`default_nettype wire

//--- vgagr_host_model.sv
/*
  Host processor model: single 8-bit I/O port reads and writes.
  Assumes one clock; requests start 1 ns after a rising edge.
*/
`default_nettype none

module vgagr_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Host I/O port bus
  output var  logic [15:0] io_addr,
  output var  logic        io_wr,
  output var  logic        io_rd,
  output var  logic [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata_ff,
  input  wire logic        io_rack_ff
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Bus idle state
  // ----------------------------------------
  initial begin
    io_addr  = 16'hffff;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h5a;
  end

  // Write strobe held across exactly one sampling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    io_wr    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask

  // Read answer lasts one cycle, so sample right after the taking edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ack);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    io_rd   = 1'b0;
    io_addr = ~a;
    d       = io_rdata_ff;
    ack     = io_rack_ff;
  endtask
endmodule

`default_nettype wire

//--- vgagr_params.svh
/*
  Constants of the general register group: I/O port addresses, bit
  positions, masks and reset values.
  Assumes it is included by bare name from the design files and the testbench.
*/
// Functional notes
// - Misc bits 7/6 set vsync/hsync polarity; pair gives 400/350/480 lines, 00 invalid.
// - Misc bit 5 picks the low or high memory page for odd/even.
// - Misc bits 3:2 map to the 4-bit video clock select code.
// - Misc bit 1 low refuses processor video memory access; high permits it.
// - Misc bit 0 chooses monochrome or colour I/O address set.
// - Feature bit 3 ORs vertical display enable into monitor vsync; others read zero.
// - Input status 0 shows retrace interrupt pending on bit 7, switch sense bit 4.
// - Input status 1 bits 5:4 show colour components picked by plane enable code.
// - Pixel-bit diagnostic mapping returns P2/P0, P5/P4, P3/P1, P7/P6 per code.
// - Input status 1 bit 3 reads one during vertical retrace.
// - Input status 1 bit 0 reads zero in display period, one in retrace.
// - Enable register at two ports; 3C3 writes bit 0, 46E8 writes bit 3.
// - Segment 0 holds 6-bit write segment in dual mode, else 3+3 split.
// - Segment 1 holds 6-bit read segment in dual mode, else fully reserved.
`ifndef VGAGR_PARAMS_SVH
`define VGAGR_PARAMS_SVH

// ----------------------------------------------------------------------
// Port addresses
// ----------------------------------------------------------------------
`define VGAGR_PORT_IS1_MONO  16'h03ba
`define VGAGR_PORT_IS1_COLOR 16'h03da
`define VGAGR_PORT_MISC_W    16'h03c2
`define VGAGR_PORT_MISC_R    16'h03cc
`define VGAGR_PORT_VGAEN     16'h03c3
`define VGAGR_PORT_VGAEN_ALT 16'h46e8
`define VGAGR_PORT_FEAT_R    16'h03ca
`define VGAGR_PORT_SEG_RD    16'h03cb
`define VGAGR_PORT_SEG_WR    16'h03cd

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define VGAGR_MISC_VPOL      7
`define VGAGR_MISC_HPOL      6
`define VGAGR_MISC_PAGE      5
`define VGAGR_MISC_CLK_HI    3
`define VGAGR_MISC_CLK_LO    2
`define VGAGR_MISC_RAMEN     1
`define VGAGR_MISC_IOSEL     0
`define VGAGR_MISC_MASK      8'hef
`define VGAGR_FEAT_VSSEL     3
`define VGAGR_FEAT_MASK      8'h08
`define VGAGR_IS0_IRQ        7
`define VGAGR_IS0_SWSENSE    4
`define VGAGR_IS1_DIAG_HI    5
`define VGAGR_IS1_DIAG_LO    4
`define VGAGR_IS1_VRETR      3
`define VGAGR_IS1_DISPN      0
`define VGAGR_VGAEN_MAIN     0
`define VGAGR_VGAEN_ALT      3
`define VGAGR_SEG_MASK       8'h3f
`define VGAGR_SEG_HI_HI      5
`define VGAGR_SEG_HI_LO      3
`define VGAGR_SEG_LO_HI      2
`define VGAGR_SEG_LO_LO      0
`define VGAGR_SRB_DUAL       3
`define VGAGR_CLK_25M        4'h0
`define VGAGR_CLK_28M        4'h1
`define VGAGR_RST_BYTE       8'h00

`endif

//--- vgagr_pkg.sv
/*
  Types of the general register group: pin bundle, register image,
  control outputs and enumerations.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package vgagr_pkg;

  // Vertical resolution implied by the sync polarity pair
  typedef enum logic [1:0] {
    VGAGR_LINES_INVALID = 2'b00,
    VGAGR_LINES_400     = 2'b01,
    VGAGR_LINES_350     = 2'b10,
    VGAGR_LINES_480     = 2'b11
  } vgagr_lines_e;

  // Colour plane enable code for diagnostic read-back
  typedef enum logic [1:0] {
    VGAGR_CPE_0 = 2'b00,
    VGAGR_CPE_1 = 2'b01,
    VGAGR_CPE_2 = 2'b10,
    VGAGR_CPE_3 = 2'b11
  } vgagr_cpe_e;

  // Asynchronous status pins from the display pipe
  typedef struct packed {
    logic       vretrace;
    logic       disp_en;
    logic       vde;
    logic       vsync;
    logic       irq_pending;
    logic       switch_sense;
    logic [7:0] pixel;
    logic       red;
    logic       green;
    logic       blue;
    logic       sec_red;
    logic       sec_green;
    logic       sec_blue;
  } vgagr_pins_s;

  // Stored register image
  typedef struct packed {
    logic [7:0] misc;
    logic [7:0] feat;
    logic [7:0] vgaen;
    logic [7:0] seg0;
    logic [7:0] seg1;
  } vgagr_regs_s;

  // Decoded controls towards the rest of the controller
  typedef struct packed {
    logic         vsync_neg;
    logic         hsync_neg;
    vgagr_lines_e lines;
    logic         sync_invalid;
    logic         page_high;
    logic [3:0]   video_clock_freq_select;
    logic         mem_access_en;
    logic         color_emul;
    logic         vsync_or_vde;
    logic         vga_enable;
    logic         dual_seg;
    logic [5:0]   write_segment;
    logic [5:0]   read_segment;
  } vgagr_ctrl_s;

endpackage

`default_nettype wire

//--- vgagr_sync.sv
/*
  Two flip-flop level synchroniser, one stage pair per bit.
  Assumes inputs are slow levels; pulses shorter than one clock may vanish.
*/
`default_nettype none

module vgagr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  // ----------------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      logic hold_ff;
      // First stage feeds only the second
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          meta_ff <= 1'b0;
          hold_ff <= 1'b0;
        end else begin
          meta_ff <= d[i];
          hold_ff <= meta_ff;
        end
      end
      assign q[i] = hold_ff;
    end
  endgenerate

endmodule

`default_nettype wire
